// [hw/ptb_core.v]
// What this block does
// - packet code 0x000A marks a pass-through bus access request.
// - byte 0x0A is true transfer count, at most 244.
// - mode bits 3-4: 0 driver access, 1-3 raw on bus one-three.
// - bit0 read/write, bit1 burst/singles, bit2 inter-byte delay enable.
// - bits 8-13 delay in 50 us steps; 0-3 invalid; ignored if disabled.
// - bytes 0x06-0x07 SPI rate kHz, low byte first.
// - I2C bus ignores requested rate, uses configured rate.
// - SPI clock is oscillator over 2,3,4,6,8,16 or 32.
// - unreachable rate picks highest achievable rate below request; below oscillator/32 it picks divisor 32.
// - byte 0x08 SPI command format in raw, sensor id in driver.
// - byte 0x09 I2C 7-bit address or SPI chip-select pin.
// - byte 0x0B is first external register.
// - payload from 0x0C only on writes.
// - raw mode bit5 selects three-wire SPI; on I2C buses it still reaches spi_3wire_o.
// - raw bits 6 and 7 set SPI polarity and phase.
// - raw bit14 makes chip select active high.
// - raw bit15 shifts bytes low bit first.
// - driver mode goes through sensor driver; raw uses packet fields.
// - format byte: bits0-3 address shift, bit4 read polarity, bits5-7 position.
// - reads write register address first, then restart or separate read.
// - result code 0x0005; 1 success, 2 I2C error, 3 rejected; SPI never reports 2.
`timescale 1ns/100ps
`default_nettype none
`include "ptb_regs.vh"
module ptb_core #(
    parameter OSC_KHZ = 20000,
    parameter [3:0] BUS_IS_SPI = 4'h6
) (
    input wire clk_i,
    input wire rst_i,
    input wire ce_i,
    input wire byte_vld_i,
    input wire [7:0] byte_i,
    input wire pkt_end_i,
    input wire xfer_ack_i,
    input wire xfer_err_i,
    input wire [7:0] xfer_rdata_i,
    input wire xfer_rvld_i,
    output reg xfer_go_o,
    output reg xfer_drv_o,
    output reg [1:0] xfer_bus_o,
    output reg xfer_wr_o,
    output reg xfer_multi_o,
    output reg [5:0] xfer_dly_o,
    output reg [15:0] xfer_dly_cyc_o,
    output reg [5:0] spi_div_o,
    output reg spi_3wire_o,
    output reg spi_cpol_o,
    output reg spi_cpha_o,
    output reg spi_cs_high_o,
    output reg low_bit_order_o,
    output reg [7:0] spi_cmd_o,
    output reg [7:0] sensor_id_o,
    output reg [7:0] target_o,
    output reg [7:0] num_o,
    output reg [7:0] reg_o,
    output reg wdata_vld_o,
    output reg [7:0] wdata_o,
    output reg res_vld_o,
    output reg [15:0] res_code_o,
    output reg [7:0] res_status_o,
    output reg [15:0] res_mode_o,
    output reg [15:0] res_rate_o,
    output reg rdata_vld_o,
    output reg [7:0] rdata_o
);
    localparam integer STEP_INT = `PTB_DLY_STEP_NS / `PTB_CLK_NS;
    localparam [15:0] STEP_CYC = STEP_INT[15:0];
    localparam [3:0] S_HDR = 4'h1;
    localparam [3:0] S_SKIP = 4'h2;
    localparam [3:0] S_RUN = 4'h4;
    localparam [3:0] S_DONE = 4'h8;
    reg [3:0] st_r;
    reg [7:0] idx_r;
    reg [15:0] code_r;
    reg [15:0] mode_r;
    reg [15:0] rate_r;
    reg [7:0] cfg_r;
    reg [7:0] addr_r;
    reg [7:0] num_r;
    reg [7:0] reg_r;
    reg [7:0] wcnt_r;
    reg [7:0] status_r;
    wire [1:0] bus_w;
    wire raw_w, wr_w, multi_w, dly_en_w, bad_w, rd_pol_w;
    wire [5:0] dly_w;
    wire [3:0] shift_w;
    wire [2:0] rd_pos_w;
    wire [5:0] div_w;
    reg [7:0] cmd_nxt;
    wire is_spi_w = BUS_IS_SPI[bus_w];
    ptb_cfg_decode u_dec (
        .mode_i(mode_r),
        .cfg_i(cfg_r),
        .num_i(num_r),
        .bus_o(bus_w),
        .raw_o(raw_w),
        .wr_o(wr_w),
        .multi_o(multi_w),
        .dly_en_o(dly_en_w),
        .dly_o(dly_w),
        .bad_o(bad_w),
        .addr_shift_o(shift_w),
        .rd_pol_o(rd_pol_w),
        .rd_pos_o(rd_pos_w)
    );
    ptb_rate_sel #(.OSC_KHZ(OSC_KHZ)) u_rate (
        .rate_khz_i(rate_r),
        .div_o(div_w)
    );
    // ------------------------------
    // spi command byte
    // ------------------------------
    always @* begin
        // register byte is still on byte_i when the command is built
        cmd_nxt = byte_i << shift_w;
        cmd_nxt[rd_pos_w] = wr_w ? ~rd_pol_w : rd_pol_w;
    end
    // ------------------------------
    // packet capture and dispatch
    // ------------------------------
    always @(posedge clk_i) begin
        if (rst_i) begin
            st_r <= S_HDR;
            idx_r <= 8'h00;
            code_r <= 16'h0000;
            mode_r <= 16'h0000;
            rate_r <= 16'h0000;
            cfg_r <= 8'h00;
            addr_r <= 8'h00;
            num_r <= 8'h00;
            reg_r <= 8'h00;
            wcnt_r <= 8'h00;
            status_r <= 8'h00;
            xfer_go_o <= 1'b0;
            xfer_drv_o <= 1'b0;
            xfer_bus_o <= 2'h0;
            xfer_wr_o <= 1'b0;
            xfer_multi_o <= 1'b0;
            xfer_dly_o <= 6'h00;
            xfer_dly_cyc_o <= 16'h0000;
            spi_div_o <= 6'h00;
            spi_3wire_o <= 1'b0;
            spi_cpol_o <= 1'b0;
            spi_cpha_o <= 1'b0;
            spi_cs_high_o <= 1'b0;
            low_bit_order_o <= 1'b0;
            spi_cmd_o <= 8'h00;
            sensor_id_o <= 8'h00;
            target_o <= 8'h00;
            num_o <= 8'h00;
            reg_o <= 8'h00;
            wdata_vld_o <= 1'b0;
            wdata_o <= 8'h00;
            res_vld_o <= 1'b0;
            res_code_o <= 16'h0000;
            res_status_o <= 8'h00;
            res_mode_o <= 16'h0000;
            res_rate_o <= 16'h0000;
            rdata_vld_o <= 1'b0;
            rdata_o <= 8'h00;
        end else if (ce_i) begin
            xfer_go_o <= 1'b0;
            wdata_vld_o <= 1'b0;
            res_vld_o <= 1'b0;
            rdata_vld_o <= xfer_rvld_i && st_r == S_RUN && !xfer_wr_o;
            rdata_o <= xfer_rdata_i;
            case (st_r)
                S_HDR: begin
                    if (byte_vld_i) begin
                        idx_r <= idx_r + 8'h01;
                        case (idx_r)
                            `PTB_OFS_CMD_LO: code_r[7:0] <= byte_i;
                            `PTB_OFS_CMD_HI: code_r[15:8] <= byte_i;
                            `PTB_OFS_MODE_LO: mode_r[7:0] <= byte_i;
                            `PTB_OFS_MODE_HI: mode_r[15:8] <= byte_i;
                            `PTB_OFS_RATE_LO: rate_r[7:0] <= byte_i;
                            `PTB_OFS_RATE_HI: rate_r[15:8] <= byte_i;
                            `PTB_OFS_CFG: cfg_r <= byte_i;
                            `PTB_OFS_ADDR: addr_r <= byte_i;
                            `PTB_OFS_NUM: num_r <= byte_i;
                            `PTB_OFS_REG: reg_r <= byte_i;
                            default: ;
                        endcase
                        if (idx_r == `PTB_OFS_CMD_HI && {byte_i, code_r[7:0]} != `PTB_CMD_CODE)
                            st_r <= S_SKIP;
                    end
                    if (byte_vld_i && idx_r == `PTB_OFS_REG) begin
                        if (bad_w) begin
                            status_r <= `PTB_ST_REJECT;
                            st_r <= S_DONE;
                        end else begin
                            xfer_go_o <= 1'b1;
                            xfer_drv_o <= !raw_w;
                            xfer_bus_o <= bus_w;
                            xfer_wr_o <= wr_w;
                            xfer_multi_o <= multi_w;
                            xfer_dly_o <= dly_w;
                            xfer_dly_cyc_o <= dly_w * STEP_CYC;
                            spi_div_o <= (raw_w && is_spi_w) ? div_w : 6'h00;
                            // reserved bits only reach the bus in raw mode
                            spi_3wire_o <= raw_w && mode_r[`PTB_BIT_3WIRE];
                            spi_cpol_o <= raw_w && mode_r[`PTB_BIT_CPOL];
                            spi_cpha_o <= raw_w && mode_r[`PTB_BIT_CPHA];
                            spi_cs_high_o <= raw_w && mode_r[`PTB_BIT_CS_HIGH];
                            low_bit_order_o <= raw_w && mode_r[`PTB_BIT_LOW_FIRST];
                            spi_cmd_o <= raw_w ? cmd_nxt : 8'h00;
                            sensor_id_o <= raw_w ? 8'h00 : cfg_r;
                            target_o <= addr_r;
                            num_o <= num_r;
                            reg_o <= byte_i;
                            wcnt_r <= 8'h00;
                            st_r <= S_RUN;
                        end
                    end
                end
                S_RUN: begin
                    if (byte_vld_i && xfer_wr_o && wcnt_r < num_o) begin
                        wdata_vld_o <= 1'b1;
                        wdata_o <= byte_i;
                        wcnt_r <= wcnt_r + 8'h01;
                    end
                    if (xfer_ack_i) begin
                        // spi cannot see a missing target
                        status_r <= (xfer_err_i && !(raw_w && is_spi_w)) ?
                            `PTB_ST_NACK : `PTB_ST_OK;
                        st_r <= S_DONE;
                    end
                end
                S_DONE: begin
                    res_vld_o <= 1'b1;
                    res_code_o <= `PTB_RES_CODE;
                    res_status_o <= status_r;
                    res_mode_o <= mode_r;
                    res_rate_o <= (raw_w && is_spi_w) ? rate_r : 16'h0000;
                    st_r <= S_SKIP;
                end
                S_SKIP: begin
                    if (pkt_end_i) begin
                        // padding dropped up to packet end
                        idx_r <= 8'h00;
                        st_r <= S_HDR;
                    end
                end
                default: st_r <= S_HDR;
            endcase
        end
    end
endmodule
`default_nettype wire

// [pkg/ptb_regs.vh]
`ifndef PTB_REGS_VH
`define PTB_REGS_VH
`define PTB_CMD_CODE 16'h000A
`define PTB_RES_CODE 16'h0005
`define PTB_OFS_CMD_LO 8'h00
`define PTB_OFS_CMD_HI 8'h01
`define PTB_OFS_LEN_LO 8'h02
`define PTB_OFS_LEN_HI 8'h03
`define PTB_OFS_MODE_LO 8'h04
`define PTB_OFS_MODE_HI 8'h05
`define PTB_OFS_RATE_LO 8'h06
`define PTB_OFS_RATE_HI 8'h07
`define PTB_OFS_CFG 8'h08
`define PTB_OFS_ADDR 8'h09
`define PTB_OFS_NUM 8'h0A
`define PTB_OFS_REG 8'h0B
`define PTB_OFS_DATA 8'h0C
`define PTB_MAX_BYTES 8'hF4
`define PTB_MIN_DELAY 6'h04
`define PTB_BIT_DIR 0
`define PTB_BIT_MULTI 1
`define PTB_BIT_DLY_EN 2
`define PTB_BUS_LO 3
`define PTB_BUS_HI 4
`define PTB_BIT_3WIRE 5
`define PTB_BIT_CPOL 6
`define PTB_BIT_CPHA 7
`define PTB_DLY_LO 8
`define PTB_DLY_HI 13
`define PTB_BIT_CS_HIGH 14
`define PTB_BIT_LOW_FIRST 15
`define PTB_SHIFT_LO 0
`define PTB_SHIFT_HI 3
`define PTB_BIT_RD_POL 4
`define PTB_RDPOS_LO 5
`define PTB_RDPOS_HI 7
`define PTB_ST_OK 8'h01
`define PTB_ST_NACK 8'h02
`define PTB_ST_REJECT 8'h03
`define PTB_DLY_STEP_NS 50000
`define PTB_CLK_NS 100
`define PTB_DIV_N 7
`endif

// [hw/ptb_rate_sel.v]
`timescale 1ns/100ps
`default_nettype none
// ------------------------------
// picks smallest divisor that fits
// ------------------------------
module ptb_rate_sel #(
    parameter OSC_KHZ = 20000
) (
    input wire [15:0] rate_khz_i,
    output reg [5:0] div_o
);
    function [5:0] div_at;
        input [2:0] k;
        begin
            case (k)
                3'h0: div_at = 6'h02;
                3'h1: div_at = 6'h03;
                3'h2: div_at = 6'h04;
                3'h3: div_at = 6'h06;
                3'h4: div_at = 6'h08;
                3'h5: div_at = 6'h10;
                default: div_at = 6'h20;
            endcase
        end
    endfunction
    integer k;
    reg found;
    always @* begin
        found = 1'b0;
        div_o = div_at(3'h6);
        for (k = 0; k < `PTB_DIV_N; k = k + 1) begin
            if (!found && (rate_khz_i * div_at(k[2:0])) >= OSC_KHZ) begin
                found = 1'b1;
                div_o = div_at(k[2:0]);
            end
        end
    end
endmodule
`default_nettype wire

// [hw/ptb_cfg_decode.v]
`timescale 1ns/100ps
`default_nettype none
// ------------------------------
// mode and command-format decode
// ------------------------------
module ptb_cfg_decode (
    input wire [15:0] mode_i,
    input wire [7:0] cfg_i,
    input wire [7:0] num_i,
    output wire [1:0] bus_o,
    output wire raw_o,
    output wire wr_o,
    output wire multi_o,
    output wire dly_en_o,
    output wire [5:0] dly_o,
    output wire bad_o,
    output wire [3:0] addr_shift_o,
    output wire rd_pol_o,
    output wire [2:0] rd_pos_o
);
    assign bus_o = mode_i[`PTB_BUS_HI:`PTB_BUS_LO];
    assign raw_o = (bus_o != 2'h0);
    assign wr_o = mode_i[`PTB_BIT_DIR];
    assign multi_o = mode_i[`PTB_BIT_MULTI];
    assign dly_en_o = mode_i[`PTB_BIT_DLY_EN];
    assign dly_o = dly_en_o ? mode_i[`PTB_DLY_HI:`PTB_DLY_LO] : 6'h00;
    assign bad_o = (dly_en_o && dly_o < `PTB_MIN_DELAY) || (num_i > `PTB_MAX_BYTES);
    assign addr_shift_o = cfg_i[`PTB_SHIFT_HI:`PTB_SHIFT_LO];
    assign rd_pol_o = cfg_i[`PTB_BIT_RD_POL];
    assign rd_pos_o = cfg_i[`PTB_RDPOS_HI:`PTB_RDPOS_LO];
endmodule
`default_nettype wire

// [testbench/ptb_core_props.sv]
`timescale 1ns/100ps
`default_nettype none
// ------------------------------
// port relations of the core
// ------------------------------
module ptb_core_props (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic byte_vld_i,
    input wire logic [7:0] byte_i,
    input wire logic xfer_ack_i,
    input wire logic xfer_err_i,
    input wire logic xfer_rvld_i,
    input wire logic [7:0] xfer_rdata_i,
    input wire logic xfer_go_o,
    input wire logic xfer_drv_o,
    input wire logic [1:0] xfer_bus_o,
    input wire logic [5:0] xfer_dly_o,
    input wire logic [15:0] xfer_dly_cyc_o,
    input wire logic [5:0] spi_div_o,
    input wire logic wdata_vld_o,
    input wire logic [7:0] wdata_o,
    input wire logic res_vld_o,
    input wire logic [15:0] res_code_o,
    input wire logic [7:0] res_status_o,
    input wire logic rdata_vld_o,
    input wire logic [7:0] rdata_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    property p_go_byte;
        xfer_go_o |-> $past(ce_i && byte_vld_i);
    endproperty
    a_go_byte: assert property (p_go_byte) else $error("go without a taken byte");
    property p_wdata;
        wdata_vld_o |-> $past(byte_vld_i) && wdata_o == $past(byte_i);
    endproperty
    a_wdata: assert property (p_wdata) else $error("write byte not echoed");
    property p_rdata;
        xfer_rvld_i && ce_i |=> rdata_vld_o && rdata_o == $past(xfer_rdata_i);
    endproperty
    a_rdata: assert property (p_rdata) else $error("read byte not echoed");
    property p_res_lat;
        xfer_ack_i && ce_i |-> ##2 res_vld_o && res_code_o == 16'h0005;
    endproperty
    a_res_lat: assert property (p_res_lat) else $error("result late or bad code");
    property p_nack;
        res_vld_o && res_status_o == 8'h02 |-> $past(xfer_err_i, 2);
    endproperty
    a_nack: assert property (p_nack) else $error("error status without error");
    property p_drv;
        xfer_go_o |-> xfer_drv_o == (xfer_bus_o == 2'h0) && !(xfer_drv_o && spi_div_o != 6'h00);
    endproperty
    a_drv: assert property (p_drv) else $error("driver mode decode wrong");
    property p_div;
        xfer_go_o && spi_div_o != 6'h00 |-> spi_div_o inside {2, 3, 4, 6, 8, 16, 32};
    endproperty
    a_div: assert property (p_div) else $error("divisor not allowed");
    property p_dly;
        xfer_go_o && xfer_dly_cyc_o != 16'h0000 |-> xfer_dly_o >= 6'h04
            && xfer_dly_cyc_o == xfer_dly_o * 500;
    endproperty
    a_dly: assert property (p_dly) else $error("delay cycles wrong");
endmodule
bind ptb_core ptb_core_props u_props (.clk_i, .rst_i, .ce_i, .byte_vld_i, .byte_i, .xfer_ack_i,
    .xfer_err_i, .xfer_rvld_i, .xfer_rdata_i, .xfer_go_o, .xfer_drv_o, .xfer_bus_o, .xfer_dly_o,
    .xfer_dly_cyc_o, .spi_div_o, .wdata_vld_o, .wdata_o, .res_vld_o, .res_code_o, .res_status_o,
    .rdata_vld_o, .rdata_o);
`default_nettype wire

// [testbench/ptb_eng_model.sv]
`timescale 1ns/100ps
`default_nettype none
module ptb_eng_model (
    input wire logic clk_i,
    input wire logic go_i,
    input wire logic wr_i,
    input wire logic err_i,
    input wire logic [7:0] num_i,
    input wire logic [3:0] lat_i,
    output logic ack_o,
    output logic err_o,
    output logic rvld_o,
    output logic [7:0] rdata_o
);
    int k;
    initial begin
        {ack_o, err_o, rvld_o, rdata_o} = '0;
        forever begin
            @(posedge clk_i);
            if (go_i === 1'b1) begin
                repeat (int'(lat_i) + int'(num_i)) @(posedge clk_i);
                for (k = 0; k < num_i && !wr_i; k++) begin
                    #1 rvld_o = 1'b1;
                    rdata_o = k[7:0] ^ 8'h5A;
                    @(posedge clk_i);
                end
                #1 rvld_o = 1'b0;
                rdata_o = ~rdata_o;
                ack_o = 1'b1;
                err_o = err_i;
                @(posedge clk_i);
                #1 ack_o = 1'b0;
                err_o = ~err_o;
            end
        end
    end
endmodule
`default_nettype wire

// [testbench/tb.sv]
`timescale 1ns/100ps
`default_nettype none
module tb;
    localparam logic [3:0] SPI_MASK = 4'h6;
    logic clk_i = 0, rst_i = 1, ce_i = 1, byte_vld_i = 0, pkt_end_i = 0, e_err = 0;
    logic xfer_ack_i, xfer_err_i, xfer_rvld_i, xfer_go_o, xfer_drv_o, xfer_wr_o, xfer_multi_o;
    logic spi_3wire_o, spi_cpol_o, spi_cpha_o, spi_cs_high_o, low_bit_order_o;
    logic wdata_vld_o, res_vld_o, rdata_vld_o;
    logic [1:0] xfer_bus_o;
    logic [3:0] e_lat = 0;
    logic [5:0] xfer_dly_o, spi_div_o;
    logic [7:0] byte_i = 0, xfer_rdata_i, spi_cmd_o, sensor_id_o, target_o, num_o, reg_o;
    logic [7:0] wdata_o, res_status_o, rdata_o, r_st;
    logic [15:0] xfer_dly_cyc_o, res_code_o, res_mode_o, res_rate_o, r_md, r_rt;
    logic [7:0] cur [0:259];
    logic [15:0] rts [10] = '{16'h2710, 16'h270F, 16'h1388, 16'h1387, 16'h0D06,
        16'h09C4, 16'h04E2, 16'h0271, 16'h0064, 16'hFFFF};
    logic [31:0] seed = 32'hA4ACD190, m, k;
    int mismatches = 0, checked = 0, go_n = 0, res_n = 0, wd_n = 0, rd_n = 0, cyc = 0, i, j;
    ptb_core #(.OSC_KHZ(20000), .BUS_IS_SPI(SPI_MASK)) u_dut (.clk_i, .rst_i, .ce_i,
        .byte_vld_i, .byte_i, .pkt_end_i, .xfer_ack_i, .xfer_err_i, .xfer_rdata_i, .xfer_rvld_i,
        .xfer_go_o, .xfer_drv_o, .xfer_bus_o, .xfer_wr_o, .xfer_multi_o, .xfer_dly_o,
        .xfer_dly_cyc_o, .spi_div_o, .spi_3wire_o, .spi_cpol_o, .spi_cpha_o, .spi_cs_high_o,
        .low_bit_order_o, .spi_cmd_o, .sensor_id_o, .target_o, .num_o, .reg_o, .wdata_vld_o,
        .wdata_o, .res_vld_o, .res_code_o, .res_status_o, .res_mode_o, .res_rate_o,
        .rdata_vld_o, .rdata_o);
    ptb_eng_model u_eng (.clk_i, .go_i(xfer_go_o), .wr_i(xfer_wr_o), .err_i(e_err),
        .num_i(num_o), .lat_i(e_lat), .ack_o(xfer_ack_i), .err_o(xfer_err_i),
        .rvld_o(xfer_rvld_i), .rdata_o(xfer_rdata_i));
    initial forever #50 clk_i = ~clk_i;
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [5:0] ediv(input logic [15:0] r);
        int d[7] = '{2, 3, 4, 6, 8, 16, 32};
        ediv = 6'h20;
        for (int n = 6; n >= 0; n--) if (r * d[n] >= 20000) ediv = d[n][5:0];
    endfunction
    function automatic logic [7:0] ecmd(input logic [7:0] rg, cf, input logic wr);
        ecmd = rg << cf[3:0];
        ecmd[cf[7:5]] = wr ? ~cf[4] : cf[4];
    endfunction
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask
    task final_report;
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // ------------------------------
    // monitor of output pulses
    // ------------------------------
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 40000) begin
            mismatches++;
            final_report;
        end
        if (xfer_go_o === 1'b1) go_n++;
        if (wdata_vld_o === 1'b1) begin
            chk("wdata", wdata_o, cur[12 + wd_n]);
            wd_n++;
        end
        if (rdata_vld_o === 1'b1) begin
            chk("rdata", rdata_o, rd_n[7:0] ^ 8'h5A);
            rd_n++;
        end
        if (res_vld_o === 1'b1) begin
            {r_st, r_md, r_rt} = {res_status_o, res_mode_o, res_rate_o};
            res_n++;
        end
    end
    task run(input logic [15:0] md, rt, input logic [7:0] cf, ad, nm, rg, input logic e, bc);
        logic [1:0] bus;
        logic spi, rej;
        int n, g0, r0;
        bus = md[4:3];
        spi = SPI_MASK[bus] && bus != 2'h0;
        rej = (md[2] && md[13:8] < 6'h04) || nm > 8'hF4;
        n = ((12 + (md[0] ? nm : 0) + 3) / 4) * 4;
        {cur[1], cur[0]} = bc ? 16'h000B : 16'h000A;
        {cur[3], cur[2]} = 16'(n - 4);
        {cur[5], cur[4], cur[7], cur[6]} = {md, rt};
        {cur[8], cur[9], cur[10], cur[11]} = {cf, ad, nm, rg};
        for (i = 12; i < n; i++) cur[i] = 8'(rnd());
        e_err = e;
        e_lat = 4'(rnd());
        {g0, r0, wd_n, rd_n} = {go_n, res_n, 64'h0};
        for (i = 0; i <= n; i++) begin
            @(posedge clk_i);
            if (e_lat[0] && i == 5) begin
                // frozen cycle must not take the stray byte
                #1 {ce_i, byte_vld_i, byte_i} = {1'b0, 1'b1, 8'hFF};
                @(posedge clk_i);
            end
            #1 ce_i = 1'b1;
            byte_vld_i = i < n;
            byte_i = cur[i];
            if (i == 12) chk("go", xfer_go_o, !rej && !bc);
        end
        if (bc) repeat (40) @(posedge clk_i);
        else for (i = 0; i < 3000 && res_n == r0; i++) @(posedge clk_i);
        #1 chk("results", res_n - r0, !bc);
        if (!bc) chk("status", r_st, rej ? 3 : (e && !spi) ? 2 : 1);
        if (!rej && !bc) begin
            chk("mode", r_md, md);
            if (bus != 2'h0) chk("rate", r_rt, spi ? rt : 16'h0000);
            chk("gos", go_n - g0, 1);
            chk("drv", {xfer_drv_o, xfer_bus_o}, {bus == 2'h0, bus});
            chk("dir", {xfer_multi_o, xfer_wr_o}, md[1:0]);
            chk("frame", {num_o, reg_o, target_o}, {nm, rg, ad});
            chk("div", spi_div_o, spi ? ediv(rt) : 6'h00);
            chk("dly", {xfer_dly_o, xfer_dly_cyc_o},
                md[2] ? {md[13:8], 16'(md[13:8] * 500)} : 0);
            if (spi) chk("spi", {low_bit_order_o, spi_cs_high_o, spi_cpha_o, spi_cpol_o,
                spi_3wire_o}, {md[15:14], md[7:5]});
            if (spi) chk("cmd", spi_cmd_o, ecmd(rg, cf, md[0]));
            if (bus == 2'h0) chk("drvbits", {sensor_id_o, low_bit_order_o, spi_cs_high_o,
                spi_cpha_o, spi_cpol_o, spi_3wire_o}, {cf, 5'h00});
            chk("wbytes", wd_n, md[0] ? nm : 0);
            chk("rbytes", rd_n, md[0] ? 0 : nm);
        end
        @(posedge clk_i);
        #1 pkt_end_i = 1'b1;
        @(posedge clk_i);
        #1 pkt_end_i = 1'b0;
    endtask
    initial begin
        repeat (8) @(posedge clk_i);
        #1 rst_i = 1'b0;
        chk("rst", {xfer_go_o, res_vld_o, spi_div_o, num_o}, 0);
        for (j = 0; j < 10; j++) begin
            m = rnd();
            run({m[15:5], 2'(1 + j % 2), 1'b0, m[1:0]}, rts[j], m[23:16], m[31:24],
                {3'h0, m[20:16]}, m[15:8], m[4], 1'b0);
        end
        run(16'h0018, 16'h1388, 8'h00, 8'h50, 8'h04, 8'h10, 1'b1, 1'b0);
        run(16'h0019, 16'h1388, 8'h00, 8'h51, 8'h05, 8'h11, 1'b0, 1'b0);
        run(16'hC0E3, 16'h0271, 8'h2C, 8'h00, 8'h03, 8'h20, 1'b0, 1'b0);
        run(16'h030D, 16'h2710, 8'h80, 8'h03, 8'h02, 8'h0F, 1'b0, 1'b0);
        run(16'h040D, 16'h2710, 8'h81, 8'h03, 8'h03, 8'h7F, 1'b0, 1'b0);
        run(16'h0008, 16'h2710, 8'hF1, 8'h04, 8'hF5, 8'h01, 1'b0, 1'b0);
        run(16'h0010, 16'h1387, 8'h1F, 8'h05, 8'hF4, 8'h02, 1'b0, 1'b0);
        run(16'h0009, 16'h2710, 8'h00, 8'h06, 8'h02, 8'h03, 1'b0, 1'b1);
        for (j = 0; j < 12; j++) begin
            m = rnd();
            k = rnd();
            run(m[15:0], m[31:16], k[7:0], k[15:8], {3'h0, k[20:16]}, k[31:24],
                k[21] && m[4:3] != 2'h0, 1'b0);
        end
        final_report;
    end
endmodule
`default_nettype wire
